//--- hw/mcu_decode_pkg.sv
`default_nettype none
package mcu_decode_pkg;

    localparam int PC_W   = 21;
    localparam int WORD_W = 16;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // Opcode groups (top nibble) and sub-function codes
    // ------------------------------------------------------------
    localparam logic [3:0] OPC_MISC    = 4'h0;
    localparam logic [3:0] OPC_LOGIC   = 4'h1;
    localparam logic [3:0] OPC_ROTC    = 4'h3;
    localparam logic [3:0] OPC_ROTN    = 4'h4;
    localparam logic [3:0] OPC_SUB     = 4'h5;
    localparam logic [3:0] OPC_TEST    = 4'h6;
    localparam logic [3:0] OPC_SKIPSET = 4'ha;
    localparam logic [3:0] OPC_SKIPCLR = 4'hb;
    localparam logic [3:0] OPC_MOVE2   = 4'hc;
    localparam logic [3:0] OPC_BRANCH  = 4'he;
    localparam logic [3:0] OPC_SECOND  = 4'hf;

    localparam logic [1:0] FN_XOR        = 2'h2;
    localparam logic [1:0] FN_ROTR       = 2'h0;
    localparam logic [1:0] FN_ROTL       = 2'h1;
    localparam logic [1:0] FN_W_MINUS_FB = 2'h1;
    localparam logic [1:0] FN_F_MINUS_WB = 2'h2;
    localparam logic [1:0] FN_F_MINUS_W  = 2'h3;
    localparam logic [1:0] FN_TEST       = 2'h1;
    localparam logic       D_TEST        = 1'b1;

    localparam logic [7:0]  HI_JUMP    = 8'hef;
    localparam logic [7:0]  HI_LOADFSR = 8'hee;
    localparam logic [6:0]  HI_CALL    = 7'h76;
    localparam logic [7:0]  HI_RETLIT  = 8'h0c;
    localparam logic [15:0] W_POP      = 16'h0006;
    localparam logic [15:0] W_PUSH     = 16'h0005;
    localparam logic [15:0] W_SLEEP    = 16'h0003;
    localparam logic [14:0] W_INTRET   = 15'h0008;
    localparam logic [14:0] W_RETURN   = 15'h0009;

    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [4:0] FLAGS_ALL = 5'h1f;
    localparam logic [4:0] FLAGS_CZN = 5'h15;
    localparam logic [4:0] FLAGS_ZN  = 5'h14;
    localparam logic SLEEP_TIMEOUT   = 1'b1;
    localparam logic SLEEP_POWERDOWN = 1'b0;

    typedef enum logic [3:0] {
        alu_none = 4'h0, alu_rlc = 4'h1, alu_rrc = 4'h2,
        alu_rln  = 4'h3, alu_rrn = 4'h4, alu_w_minus_fb = 4'h5,
        alu_f_minus_w = 4'h6, alu_f_minus_wb = 4'h7, alu_xor = 4'h8
    } alu_op_e;

    typedef enum logic [1:0] {
        st_exec  = 2'b00,
        st_flush = 2'b01,
        st_skip  = 2'b10
    } state_e;

    typedef struct packed {
        logic negative;
        logic overflow_flag;
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } status_s;

    typedef struct packed {
        logic [3:0] opc;
        logic [1:0] fn;
        logic       d;
        logic       a;
        logic [7:0] lit;
    } instr_s;

    typedef struct packed {
        logic [7:0]      result;
        logic            w_we;
        logic            f_we;
        logic            access_bank;
        logic [7:0]      file_addr;
        status_s         flags;
        logic [4:0]      flags_we;
        logic            pc_load;
        logic [PC_W-1:0] pc_target;
        logic            stack_push;
        logic            stack_pop;
        logic [PC_W-1:0] push_addr;
        logic            fast_save;
        logic            fast_restore;
        logic            irq_reenable;
        logic            prescaler_clear;
        logic            status_we;
        logic            timeout_status_bit;
        logic            powerdown_status_bit;
        logic            bubble;
    } exec_s;

endpackage
`default_nettype wire

//--- hw/byte_alu.sv
`timescale 1ns/10ps
`default_nettype none
module byte_alu
    import mcu_decode_pkg::*;
(
    input  wire alu_op_e      op,
    input  wire logic [7:0]   w,
    input  wire logic [7:0]   f,
    input  wire logic         carry_in,
    output var  logic [7:0]   result,
    output var  status_s      flags,
    output var  logic [4:0]   flags_we
);
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic [8:0] sum;
    logic [4:0] low;

    // Borrow is carry inverted, so subtraction is a + ~b + cin
    always_comb begin
        a   = f;
        b   = ~w;
        cin = (op == alu_f_minus_w) ? 1'b1 : carry_in;
        if (op == alu_w_minus_fb) begin
            a = w;
            b = ~f;
        end
        sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    end

    always_comb begin
        result   = sum[7:0];
        flags    = '0;
        flags_we = FLAGS_ALL;
        flags.carry            = sum[8];
        flags.digit_carry_flag = low[4];
        flags.overflow_flag    = (a[7] == b[7]) && (sum[7] != a[7]);
        unique case (op)
            alu_rlc: begin
                result      = {f[6:0], carry_in};
                flags.carry = f[7];
                flags_we    = FLAGS_CZN;
            end
            alu_rrc: begin
                result      = {carry_in, f[7:1]};
                flags.carry = f[0];
                flags_we    = FLAGS_CZN;
            end
            alu_rln: begin
                result   = {f[6:0], f[7]};
                flags_we = FLAGS_ZN;
            end
            alu_rrn: begin
                result   = {f[0], f[7:1]};
                flags_we = FLAGS_ZN;
            end
            alu_xor: begin
                result   = w ^ f;
                flags_we = FLAGS_ZN;
            end
            alu_none: flags_we = '0;
            default: ;
        endcase
        flags.zero     = (result == 8'h00);
        flags.negative = result[7];
    end
endmodule
`default_nettype wire

//--- hw/branch_unit.sv
`timescale 1ns/10ps
`default_nettype none
module branch_unit
    import mcu_decode_pkg::*;
(
    input  wire logic [2:0]      cond,
    input  wire status_s         flags,
    input  wire logic [7:0]      offset,
    input  wire logic [PC_W-1:0] pc_next,
    output var  logic            taken,
    output var  logic [PC_W-1:0] target
);
    logic flag_bit;

    // Even selectors test a flag set, odd ones the flag clear
    always_comb begin
        unique case (cond[2:1])
            2'h0: flag_bit = flags.zero;
            2'h1: flag_bit = flags.carry;
            2'h2: flag_bit = flags.overflow_flag;
            2'h3: flag_bit = flags.negative;
        endcase
        taken  = flag_bit ^ cond[0];
        target = pc_next + {{(PC_W-9){offset[7]}}, offset, 1'b0};
    end
endmodule
`default_nettype wire

//--- hw/mcu_opcode_decoder_part.sv
`timescale 1ns/10ps
`default_nettype none
module mcu_opcode_decoder_part
    import mcu_decode_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              instr_valid,
    input  wire logic [WORD_W-1:0] instr_word,
    input  wire logic [WORD_W-1:0] prefetch_word,
    input  wire logic [PC_W-1:0]   pc_next,
    input  wire logic [7:0]        working_register,
    input  wire logic [7:0]        file_value,
    input  wire logic [7:0]        port_pin_value,
    input  wire logic              operand_is_port,
    input  wire logic              operand_is_timer,
    input  wire logic              prescaler_on_timer,
    input  wire status_s           flags,
    input  wire logic [PC_W-1:0]   return_stack_top,
    input  wire logic              table_write_start,
    input  wire logic              table_write_done,
    input  wire logic              wake_event,
    output var  exec_s             exec,
    output var  logic              standby,
    output var  logic              table_write_hold
);

    // ------------------------------------------------------------
    // Instruction fields and internal signals
    // ------------------------------------------------------------
    instr_s          iw;
    state_e          state;
    state_e          next_state;
    exec_s           next_exec;
    logic            next_standby;
    logic            take;
    logic [7:0]      src;
    logic            bit_val;
    alu_op_e         alu_op;
    logic [7:0]      alu_result;
    status_s         alu_flags;
    logic [4:0]      alu_flags_we;
    logic            br_taken;
    logic [PC_W-1:0] br_target;
    logic [PC_W-1:0] abs_target;
    logic            is_branch;
    logic            is_jump;
    logic            is_call;
    logic            is_retlit;
    logic            is_intret;
    logic            is_return;
    logic            skip_test;
    logic            skip_hit;

    assign iw   = instr_s'(instr_word);
    assign take = instr_valid && !standby && (state == st_exec);

    // Pins, not the output latch, feed read-modify-write of a port
    assign src = operand_is_port ? port_pin_value : file_value;
    assign bit_val = src[{iw.fn, iw.d}];

    // Upper target bits come from the prefetched second word, so the
    // redirect is issued while that word is still in the pipe
    assign abs_target = {prefetch_word[11:0], iw.lit, 1'b0};

    function automatic logic two_word(input logic [WORD_W-1:0] w);
        two_word = (w[15:12] == OPC_MOVE2) || (w[15:8] == HI_JUMP)
                || (w[15:8] == HI_LOADFSR) || (w[15:9] == HI_CALL);
    endfunction

    // ------------------------------------------------------------
    // Operation classification
    // ------------------------------------------------------------
    always_comb begin
        alu_op = alu_none;
        unique case (iw.opc)
            OPC_ROTC: begin
                if (iw.fn == FN_ROTL) alu_op = alu_rlc;
                if (iw.fn == FN_ROTR) alu_op = alu_rrc;
            end
            OPC_ROTN: begin
                if (iw.fn == FN_ROTL) alu_op = alu_rln;
                if (iw.fn == FN_ROTR) alu_op = alu_rrn;
            end
            OPC_SUB: begin
                if (iw.fn == FN_W_MINUS_FB) alu_op = alu_w_minus_fb;
                if (iw.fn == FN_F_MINUS_W) alu_op = alu_f_minus_w;
                if (iw.fn == FN_F_MINUS_WB) alu_op = alu_f_minus_wb;
            end
            OPC_LOGIC: begin
                if (iw.fn == FN_XOR) alu_op = alu_xor;
            end
            default: alu_op = alu_none;
        endcase
    end

    assign is_branch = (iw.opc == OPC_BRANCH) && !iw.fn[1];
    assign is_jump   = (instr_word[15:8] == HI_JUMP);
    assign is_call   = (instr_word[15:9] == HI_CALL);
    assign is_retlit = (instr_word[15:8] == HI_RETLIT);
    assign is_intret = (instr_word[15:1] == W_INTRET);
    assign is_return = (instr_word[15:1] == W_RETURN);

    assign skip_test = (iw.opc == OPC_SKIPCLR)
                    || (iw.opc == OPC_SKIPSET)
                    || ((iw.opc == OPC_TEST) && (iw.fn == FN_TEST)
                        && (iw.d == D_TEST));

    always_comb begin
        skip_hit = (src == 8'h00);
        if (iw.opc == OPC_SKIPCLR) skip_hit = !bit_val;
        if (iw.opc == OPC_SKIPSET) skip_hit = bit_val;
    end

    byte_alu u_alu (
        .op       (alu_op),
        .w        (working_register),
        .f        (src),
        .carry_in (flags.carry),
        .result   (alu_result),
        .flags    (alu_flags),
        .flags_we (alu_flags_we)
    );

    branch_unit u_branch (
        .cond    ({iw.fn[0], iw.d, iw.a}),
        .flags   (flags),
        .offset  (iw.lit),
        .pc_next (pc_next),
        .taken   (br_taken),
        .target  (br_target)
    );

    // ------------------------------------------------------------
    // Decode of one executed word
    // ------------------------------------------------------------
    always_comb begin
        next_exec    = '0;
        next_exec.bubble = 1'b1;
        next_state   = state;
        next_standby = 1'b0;
        if (instr_valid && !standby) begin
            unique case (state)
                st_flush: next_state = st_exec;
                st_skip: begin
                    // Skipping a two-word op costs one more slot
                    next_state = two_word(instr_word) ? st_flush
                                                      : st_exec;
                end
                st_exec: begin
                    next_state = st_exec;
                    if (alu_op != alu_none) begin
                        next_exec.bubble      = 1'b0;
                        next_exec.result      = alu_result;
                        next_exec.flags       = alu_flags;
                        next_exec.flags_we    = alu_flags_we;
                        next_exec.f_we        = iw.d;
                        next_exec.w_we        = !iw.d;
                        next_exec.access_bank = iw.a;
                        next_exec.file_addr   = iw.lit;
                        next_exec.prescaler_clear = iw.d
                            && operand_is_timer && prescaler_on_timer;
                    end else if (skip_test) begin
                        next_exec.bubble      = 1'b0;
                        next_exec.access_bank = iw.a;
                        next_exec.file_addr   = iw.lit;
                        if (skip_hit) next_state = st_skip;
                    end else if (is_jump || is_call) begin
                        next_exec.bubble    = 1'b0;
                        next_exec.pc_load   = 1'b1;
                        next_exec.pc_target = abs_target;
                        next_exec.stack_push = is_call;
                        next_exec.push_addr = pc_next + PC_STEP;
                        next_exec.fast_save = is_call && iw.a;
                        next_state = st_flush;
                    end else if (is_branch) begin
                        next_exec.bubble = 1'b0;
                        if (br_taken) begin
                            next_exec.pc_load   = 1'b1;
                            next_exec.pc_target = br_target;
                            next_state = st_flush;
                        end
                    end else if (iw.opc == OPC_SECOND) begin
                        next_exec.bubble = 1'b1;
                    end else if (instr_word == W_POP) begin
                        next_exec.bubble    = 1'b0;
                        next_exec.stack_pop = 1'b1;
                    end else if (instr_word == W_PUSH) begin
                        next_exec.bubble     = 1'b0;
                        next_exec.stack_push = 1'b1;
                        next_exec.push_addr  = pc_next;
                    end else if (instr_word == W_SLEEP) begin
                        next_exec.bubble    = 1'b0;
                        next_exec.status_we = 1'b1;
                        next_exec.timeout_status_bit   = SLEEP_TIMEOUT;
                        next_exec.powerdown_status_bit = SLEEP_POWERDOWN;
                        next_standby = 1'b1;
                    end else if (is_intret || is_return || is_retlit) begin
                        next_exec.bubble    = 1'b0;
                        next_exec.stack_pop = 1'b1;
                        next_exec.pc_load   = 1'b1;
                        next_exec.pc_target = return_stack_top;
                        next_exec.irq_reenable = is_intret;
                        next_exec.fast_restore = !is_retlit
                                                 && instr_word[0];
                        next_exec.w_we   = is_retlit;
                        next_exec.result = iw.lit;
                        next_state = st_flush;
                    end
                end
                default: next_state = st_exec;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) state <= st_exec;
        else         state <= next_state;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            exec <= '0;
        end else begin
            exec <= next_exec;
        end
    end

    // Wake and entry in the same cycle: entry wins so it is not lost
    always_ff @(posedge clock) begin
        if (!resetn)           standby <= 1'b0;
        else if (next_standby) standby <= 1'b1;
        else if (wake_event)   standby <= 1'b0;
    end

    // Nothing the decoder does (standby, redirects) may drop this;
    // only the memory's own done clears it
    always_ff @(posedge clock) begin
        if (!resetn)                table_write_hold <= 1'b0;
        else if (table_write_start) table_write_hold <= 1'b1;
        else if (table_write_done)  table_write_hold <= 1'b0;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence redirect_then_idle;
        exec.pc_load ##1 exec.bubble;
    endsequence

    chk_branch_redirect: assert property (
        take && is_branch && br_taken |=> redirect_then_idle
    ) else $error("taken branch did not redirect and idle");

    chk_branch_target: assert property (
        take && is_branch && br_taken |=> exec.pc_target ==
            $past(pc_next) + {{(PC_W-9){$past(instr_word[7])}},
                              $past(instr_word[7:0]), 1'b0}
    ) else $error("branch target wrong");

    chk_branch_fall: assert property (
        take && is_branch && !br_taken |=> !exec.pc_load
            && state == st_exec
    ) else $error("untaken branch took a second cycle");

    chk_call_push: assert property (
        take && is_call |=> exec.stack_push && exec.pc_load
            && exec.push_addr == $past(pc_next) + PC_STEP
            && exec.pc_target == {$past(prefetch_word[11:0]),
                                  $past(instr_word[7:0]), 1'b0}
    ) else $error("call did not push return and jump");

    chk_jump_cycles: assert property (
        take && is_jump && instr_valid |=> state == st_flush
            ##1 (state == st_exec || !$past(instr_valid))
    ) else $error("jump not two cycles");

    chk_lone_second: assert property (
        take && iw.opc == OPC_SECOND |=> exec.bubble && !exec.w_we
            && !exec.f_we && !exec.pc_load && !exec.stack_push
    ) else $error("lone second word did something");

    chk_port_source: assert property (
        take && alu_op == alu_xor && operand_is_port |=>
            exec.result == ($past(working_register)
                            ^ $past(port_pin_value))
    ) else $error("port rewrite did not use pin levels");

    chk_xor_flags: assert property (
        take && alu_op == alu_xor |=> exec.flags_we == FLAGS_ZN
            && exec.flags.zero == ($past(working_register) == $past(src))
    ) else $error("exclusive OR flags wrong");

    chk_rotate_carry: assert property (
        take && alu_op == alu_rlc |=> exec.flags_we == FLAGS_CZN
            && exec.result == {$past(src[6:0]), $past(flags.carry)}
            && exec.flags.carry == $past(src[7])
    ) else $error("rotate through carry wrong");

    chk_sub_flags: assert property (
        take && alu_op == alu_f_minus_w |=> exec.flags_we == FLAGS_ALL
            && exec.result == $past(src) - $past(working_register)
    ) else $error("subtract working from file wrong");

    chk_prescaler_clr: assert property (
        take && alu_op != alu_none && iw.d |=> exec.prescaler_clear
            == ($past(operand_is_timer) && $past(prescaler_on_timer))
    ) else $error("prescaler clear wrong");

    chk_dest_route: assert property (
        take && alu_op != alu_none |=> exec.f_we == $past(iw.d)
            && exec.w_we == !$past(iw.d)
    ) else $error("destination routing wrong");

    chk_skip_long: assert property (
        state == st_skip && instr_valid && !standby
            && two_word(instr_word) |=> state == st_flush
    ) else $error("skip of two-word op too short");

    chk_retlit_load: assert property (
        take && is_retlit |=> exec.w_we && exec.stack_pop
            && exec.result == $past(instr_word[7:0])
            && exec.pc_target == $past(return_stack_top)
            ##1 exec.bubble
    ) else $error("return with literal wrong");

    chk_sleep_status: assert property (
        take && instr_word == W_SLEEP |=> standby && exec.status_we
            && exec.timeout_status_bit == SLEEP_TIMEOUT
            && exec.powerdown_status_bit == SLEEP_POWERDOWN
    ) else $error("standby entry wrong");

    chk_tblwr_hold: assert property (
        table_write_hold && !table_write_done |=> table_write_hold
    ) else $error("table write dropped before done");

endmodule
`default_nettype wire

//--- verif/fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
module fetch_model
    import mcu_decode_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            resetn,
    input  wire logic            instr_valid,
    input  wire logic            table_write_start,
    output var  logic [PC_W-1:0] pc_next,
    output var  logic [PC_W-1:0] return_stack_top,
    output var  logic            table_write_done
);
    logic [1:0] wait_cnt;
    // Write ends three cycles after start, so the hold must outlast it
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pc_next <= 21'h000102;
            wait_cnt <= 2'h0;
        end else begin
            pc_next <= pc_next + (instr_valid ? PC_STEP : 21'h0);
            wait_cnt <= table_write_start ? 2'h3
                : wait_cnt - 2'(wait_cnt != 2'h0);
        end
    end
    assign table_write_done = wait_cnt == 2'h1;
    assign return_stack_top = 21'h01a2b4;
endmodule
`default_nettype wire

//--- verif/mcu_opcode_decoder_part_bench.sv
`timescale 1ns/10ps
`default_nettype none
module mcu_opcode_decoder_part_bench
    import mcu_decode_pkg::*;
();
    localparam logic [46:0] M_PC = {21'h1fffff, 26'h0};
    localparam logic [46:0] M_CTL = {21'h0, 18'h3ffff, 8'h0};
    localparam logic [5:0] ALU [8] = '{6'h0d, 6'h0c, 6'h10, 6'h15, 6'h17,
        6'h16, 6'h06, 6'h11};
    logic clock = 0, resetn = 0, instr_valid = 0, wake_event = 0, c, d, tk;
    logic operand_is_port = 0, operand_is_timer = 0, prescaler_on_timer = 0;
    logic table_write_start = 0, table_write_done, standby, table_write_hold;
    logic [15:0] instr_word = 0, prefetch_word = 0, lfsr = 16'hb46f;
    logic [7:0] w = 0, f = 0, port_pin_value = 0, s, r, off;
    logic [PC_W-1:0] pc_next, return_stack_top;
    logic [93:0] nt, q[$];
    status_s flags = '0;
    exec_s exec;
    int fail_count = 0, checks = 0, cyc = 0, k;
    mcu_opcode_decoder_part i_mcu_opcode_decoder_part (.clock, .resetn,
        .instr_valid, .instr_word, .prefetch_word, .pc_next,
        .working_register(w), .file_value(f), .port_pin_value,
        .operand_is_port, .operand_is_timer, .prescaler_on_timer, .flags,
        .return_stack_top, .table_write_start, .table_write_done,
        .wake_event, .exec, .standby, .table_write_hold);
    fetch_model i_fetch_model (.clock, .resetn, .instr_valid,
        .table_write_start, .pc_next, .return_stack_top, .table_write_done);
    always #25 clock = ~clock;
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    function automatic logic [46:0] obs();
        return {exec.pc_target, exec.bubble, exec.pc_load, exec.stack_push,
            exec.stack_pop, exec.status_we, exec.w_we, exec.f_we,
            exec.prescaler_clear, exec.irq_reenable, exec.fast_restore,
            exec.timeout_status_bit, standby, table_write_hold,
            exec.flags_we, exec.result};
    endfunction
    task automatic check(string what, logic [46:0] seen, logic [46:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Each note is judged on the falling edge after its word was taken
    task automatic issue(logic v, logic [15:0] wd, logic [12:0] st,
            logic [4:0] fw, logic [7:0] rs, logic [20:0] t, logic [46:0] m);
        instr_valid = v;
        instr_word = wd;
        q.push_back({m, t, st, fw, rs});
        @(negedge clock);
        #1;
    endtask
    task automatic flush();
        issue(1, rnd(), 13'h1000, 0, 0, 0, M_CTL);
    endtask
    task automatic conclude();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(negedge clock) begin
        if (q.size() > 0) begin
            nt = q.pop_front();
            check("exec", obs() & nt[93:47], nt[46:0] & nt[93:47]);
        end
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (12) @(negedge clock);
        check("reset", obs(), 0);
        resetn = 1;
        @(negedge clock);
        #1;
        for (int i = 0; i < 16; i++) begin
            {w, f} = rnd();
            port_pin_value = 8'(rnd());
            {operand_is_port, operand_is_timer, prescaler_on_timer, c} =
                4'(rnd()) | {i == 6, 3'b000};
            flags = {4'h0, c};
            s = operand_is_port ? port_pin_value : f;
            k = i % 8;
            d = i > 7;
            case (k)
                0: r = {s[6:0], c};
                1: r = {c, s[7:1]};
                2: r = {s[0], s[7:1]};
                3: r = w - s - 8'(!c);
                4: r = s - w;
                5: r = s - w - 8'(!c);
                7: r = {s[6:0], s[7]};
                default: r = w ^ s;
            endcase
            issue(1, {ALU[k], d, c, 8'(i)}, {5'h0, !d, d,
                d & operand_is_timer & prescaler_on_timer, 5'h0}, k < 2 ?
                FLAGS_CZN : k == 2 || k > 5 ? FLAGS_ZN : FLAGS_ALL, r, 0,
                ~M_PC);
            check("alu", {exec.access_bank, exec.file_addr, exec.flags.zero,
                exec.flags.negative}, {c, 8'(i), r == 0, r[7]});
        end
        $display("alu done");
        for (int i = 0; i < 16; i++) begin
            k = i % 8;
            flags = 5'(rnd());
            off = 8'(rnd());
            s = {4'h0, flags.negative, flags.overflow_flag, flags.carry,
                flags.zero};
            tk = s[k/2] ^ k[0];
            issue(1, {8'he0 | 8'(k), off}, {1'b0, tk, 11'h0}, 0, 0, pc_next
                + {{12{off[7]}}, off, 1'b0}, tk ? M_CTL | M_PC : M_CTL);
            if (tk) flush();
        end
        $display("branch done");
        for (int i = 0; i < 3; i++) begin
            prefetch_word = {4'hf, 12'(rnd())};
            off = 8'(rnd());
            issue(1, i == 2 ? {HI_JUMP, off} : {HI_CALL, i[0], off},
                {2'b01, i < 2, 10'h0}, 0, 0, {prefetch_word[11:0], off, 1'b0},
                M_CTL | M_PC);
            if (i < 2) check("call", {exec.fast_save, exec.push_addr},
                {i[0], pc_next});
            issue(1, prefetch_word, 13'h1000, 0, 0, 0, M_CTL);
            issue(1, 16'hf000 | 16'(rnd()), 13'h1000, 0, 0, 0, M_CTL);
        end
        operand_is_port = 0;
        for (int i = 0; i < 6; i++) begin
            k = rnd() % 8;
            tk = i < 4;
            f = 8'(rnd());
            f[k] = i[0] ? tk : !tk;
            issue(1, {i[0] ? OPC_SKIPSET : OPC_SKIPCLR, 3'(k), 9'h020}, 0, 0,
                0, 0, M_CTL);
            issue(1, i[1] ? {HI_JUMP, 8'h10} : W_PUSH, tk ? 13'h1000 :
                13'h0400, 0, 0, 0, M_CTL);
            if (tk && i[1]) flush();
        end
        f = 8'h00;
        issue(1, 16'h6620, 0, 0, 0, 0, M_CTL);
        issue(1, W_PUSH, 13'h1000, 0, 0, 0, M_CTL);
        $display("flow done");
        issue(1, W_POP, 13'h0200, 0, 0, 0, M_CTL);
        for (int i = 0; i < 3; i++) begin
            off = 8'(rnd());
            issue(1, i == 2 ? {HI_RETLIT, off} : 16'h0010 | 16'(i),
                {4'b0101, 1'b0, i == 2, 2'b00, i < 2, i == 1, 3'b000}, 0, off,
                return_stack_top, M_CTL | M_PC | (i == 2 ? 47'hff : 0));
            flush();
        end
        issue(1, W_SLEEP, 13'h0106, 0, 0, 0, M_CTL);
        issue(1, W_PUSH, 13'h1002, 0, 0, 0, M_CTL);
        wake_event = 1;
        issue(0, 0, 13'h1000, 0, 0, 0, M_CTL);
        wake_event = 0;
        table_write_start = 1;
        for (int i = 0; i < 4; i++) begin
            issue(0, 0, {12'h800, i < 3}, 0, 0, 0, M_CTL);
            table_write_start = 0;
        end
        $display("return standby table done");
        conclude();
    end
endmodule
`default_nettype wire
